// ### rtl/wtac_ctrl.sv
// wakeup timeout, oscillator keep-on and synthesizer auto-calibration control
// How it works
// - select 00: calibrate only on the host calibrate strobe
// - select 01: calibrate on every IDLE to RX transition
// - select 10: calibrate on every automatic RX to IDLE return
// - select 11: calibrate on every fourth automatic RX to IDLE return
// - after oscillator settles, wait timeout expiries of six-bit counter, then chip ready low
// - timeout field gives 1, 16, 64, 256 expiries; reset value 01
// - oscillator settled and chip ready assert in the same cycle
`timescale 1ns/1ns
module wtac_ctrl #(
    parameter int RIPPLE_BITS = wtac_pkg::RIPPLE_BITS
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    input wire logic I_SLEEP,
    input wire logic I_OSC_RAW_STABLE,
    input wire logic I_IDLE_TO_RX,
    input wire logic I_RX_TO_IDLE_AUTO,
    input wire logic I_SYNTH_CAL_STROBE,
    output logic O_OSC_ENABLE,
    output logic O_OSC_SETTLED,
    output logic O_CHIP_READY_LOW,
    output logic O_SYNTH_CAL_START
);
    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    wtac_pkg::wtac_cfg_t cfg_reg;
    wtac_pkg::wtac_evt_t evt;

    assign evt = '{idle_to_rx: I_IDLE_TO_RX, rx_to_idle_auto: I_RX_TO_IDLE_AUTO,
                   synth_calibrate_strobe: I_SYNTH_CAL_STROBE};

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            cfg_reg <= wtac_pkg::wtac_cfg_t'(wtac_pkg::WAKE_CAL_CTRL_RESET);
        end else if (I_REG_WR && I_REG_ADDR == wtac_pkg::WAKE_CAL_CTRL_ADDR) begin
            cfg_reg <= wtac_pkg::wtac_cfg_t'(I_REG_WDATA & wtac_pkg::WRITABLE_MASK);
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_REG_RDATA <= 8'h00;
        end else if (I_REG_ADDR == wtac_pkg::WAKE_CAL_CTRL_ADDR) begin
            O_REG_RDATA <= 8'(cfg_reg) & wtac_pkg::WRITABLE_MASK;
        end else begin
            O_REG_RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // oscillator enable
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_OSC_ENABLE <= 1'b1;
        end else begin
            O_OSC_ENABLE <= !I_SLEEP || cfg_reg.oscillator_keep_on;
        end
    end

    // ------------------------------------------------------------
    // power-on timeout
    // ------------------------------------------------------------
    logic [RIPPLE_BITS-1:0] ripple_reg;
    logic [8:0] expiry_reg;
    logic [8:0] expire_target;
    logic ready_reg;

    always_comb begin
        unique case (cfg_reg.power_on_timeout_select)
            2'h0: expire_target = wtac_pkg::EXPIRE_CNT_0;
            2'h1: expire_target = wtac_pkg::EXPIRE_CNT_1;
            2'h2: expire_target = wtac_pkg::EXPIRE_CNT_2;
            2'h3: expire_target = wtac_pkg::EXPIRE_CNT_3;
        endcase
    end

    // counting restarts whenever the oscillator is not settled or not enabled
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !I_OSC_RAW_STABLE || !O_OSC_ENABLE) begin
            ripple_reg <= '0;
            expiry_reg <= 9'h000;
            ready_reg <= 1'b0;
        end else if (!ready_reg) begin
            ripple_reg <= ripple_reg + 1'b1;
            if (&ripple_reg) begin
                expiry_reg <= expiry_reg + 9'h001;
                if (expiry_reg + 9'h001 >= expire_target) begin
                    ready_reg <= 1'b1;
                end
            end
        end
    end

    // both indications come from the same flop, so no offset between them
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_OSC_SETTLED <= 1'b0;
            O_CHIP_READY_LOW <= 1'b1;
        end else begin
            O_OSC_SETTLED <= ready_reg;
            O_CHIP_READY_LOW <= !ready_reg;
        end
    end

    // ------------------------------------------------------------
    // synthesizer auto-calibration
    // ------------------------------------------------------------
    logic [1:0] return_cnt_reg;
    logic auto_cal;

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            return_cnt_reg <= 2'h0;
        end else if (evt.rx_to_idle_auto) begin
            return_cnt_reg <= return_cnt_reg + 2'h1;
        end
    end

    always_comb begin
        unique case (cfg_reg.auto_calibration_select)
            wtac_pkg::AUTOCAL_NEVER: auto_cal = 1'b0;
            wtac_pkg::AUTOCAL_IDLE_TO_RX: auto_cal = evt.idle_to_rx;
            wtac_pkg::AUTOCAL_RX_TO_IDLE: auto_cal = evt.rx_to_idle_auto;
            wtac_pkg::AUTOCAL_EVERY_4TH: auto_cal = evt.rx_to_idle_auto && return_cnt_reg == 2'h3;
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_SYNTH_CAL_START <= 1'b0;
        end else begin
            O_SYNTH_CAL_START <= auto_cal || evt.synth_calibrate_strobe;
        end
    end
endmodule : wtac_ctrl

// ### rtl/wtac_pkg.sv
// package: register map, field layout and timing constants of the wakeup/calibration control block
package wtac_pkg;
    localparam logic [7:0] WAKE_CAL_CTRL_ADDR = 8'h18;
    localparam logic [7:0] WAKE_CAL_CTRL_RESET = 8'h04;
    localparam int AUTOCAL_HI = 5;
    localparam int AUTOCAL_LO = 4;
    localparam int POWER_ON_TIMEOUT_SELECT_HI = 3;
    localparam int POWER_ON_TIMEOUT_SELECT_LO = 2;
    localparam int SPARE_BIT = 1;
    localparam int KEEP_ON_BIT = 0;
    localparam logic [7:0] WRITABLE_MASK = 8'h3F;
    localparam int RIPPLE_BITS = 6;
    localparam logic [8:0] EXPIRE_CNT_0 = 9'h001;
    localparam logic [8:0] EXPIRE_CNT_1 = 9'h010;
    localparam logic [8:0] EXPIRE_CNT_2 = 9'h040;
    localparam logic [8:0] EXPIRE_CNT_3 = 9'h100;

    typedef enum logic [1:0] {
        AUTOCAL_NEVER = 2'h0,
        AUTOCAL_IDLE_TO_RX = 2'h1,
        AUTOCAL_RX_TO_IDLE = 2'h2,
        AUTOCAL_EVERY_4TH = 2'h3
    } wtac_autocal_t;

    // fields of the register as one word
    typedef struct packed {
        logic [1:0] unused;
        wtac_autocal_t auto_calibration_select;
        logic [1:0] power_on_timeout_select;
        logic spare;
        logic oscillator_keep_on;
    } wtac_cfg_t;

    // radio state machine events seen by this block
    typedef struct packed {
        logic idle_to_rx;
        logic rx_to_idle_auto;
        logic synth_calibrate_strobe;
    } wtac_evt_t;
endpackage : wtac_pkg

// ### bench/wtac_host.sv
// host model: one register write per request
`timescale 1ns/1ns
module wtac_host (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_data,
    output logic o_wr,
    output logic [7:0] o_wdata
);
    always_ff @(posedge i_clk) begin
        o_wr <= i_go;
        // keep-on set: timeout 10 so the supply settles first
        o_wdata <= i_data[0] ? {i_data[7:4], 2'h2, i_data[1:0]} : i_data;
    end
endmodule : wtac_host

// ### bench/wtac_ctrl_assertions.sv
// checker: port timing of the wakeup/calibration control block
`timescale 1ns/1ns
module wtac_ctrl_chk #(
    parameter int RIPPLE_BITS = 6
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_SLEEP,
    input wire logic I_OSC_RAW_STABLE,
    input wire logic I_IDLE_TO_RX,
    input wire logic I_RX_TO_IDLE_AUTO,
    input wire logic I_SYNTH_CAL_STROBE,
    input wire logic O_OSC_ENABLE,
    input wire logic O_OSC_SETTLED,
    input wire logic O_CHIP_READY_LOW,
    input wire logic O_SYNTH_CAL_START,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] O_REG_RDATA
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    ready_pair_a: assert property (O_OSC_SETTLED != O_CHIP_READY_LOW) else $error("ready split");
    spare_zero_a: assert property (O_REG_RDATA[7:6] == 2'h0) else $error("top bits set");
    map_only_a: assert property (O_REG_RDATA != 8'h00 |-> $past(I_REG_ADDR) == 8'h18) else $error("bad map");
    strobe_cal_a: assert property (I_SYNTH_CAL_STROBE |=> O_SYNTH_CAL_START) else $error("no cal");
    cal_cause_a: assert property (O_SYNTH_CAL_START |-> $past(I_SYNTH_CAL_STROBE) || $past(I_IDLE_TO_RX)
        || $past(I_RX_TO_IDLE_AUTO)) else $error("cal without cause");
    awake_osc_a: assert property (!I_SLEEP |=> O_OSC_ENABLE) else $error("osc off awake");
    min_wait_a: assert property ($rose(O_OSC_SETTLED) |-> $past(I_OSC_RAW_STABLE, 1 << RIPPLE_BITS))
        else $error("ready early");
    drop_ready_a: assert property (!I_OSC_RAW_STABLE |-> ##2 !O_OSC_SETTLED) else $error("ready held");
endmodule : wtac_ctrl_chk
bind wtac_ctrl wtac_ctrl_chk #(.RIPPLE_BITS(RIPPLE_BITS)) u_chk (.*);

// ### bench/wtac_ctrl_bench.sv
// bench: register, timeout, calibration and sleep checks against a reference model
`timescale 1ns/1ns
module wtac_ctrl_bench;
    logic clk = 0, rst = 1, go = 0, slp = 0, stab = 0, itr = 0, rti = 0, stb = 0, wr, osc, settled, rdy_n, cal;
    logic [7:0] ad = 8'h18, dt = 8'h00, h_dt, rdata;
    integer n_mismatch = 0, checks_done = 0, seed = 56, acnt = 0, n, m, k, e;
    wtac_host u_wtac_host (.i_clk(clk), .i_go(go), .i_data(dt), .o_wr(wr), .o_wdata(h_dt));
    wtac_ctrl u_wtac_ctrl (.I_MCLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_ADDR(ad), .I_REG_WDATA(h_dt),
        .O_REG_RDATA(rdata), .I_SLEEP(slp), .I_OSC_RAW_STABLE(stab), .I_IDLE_TO_RX(itr), .I_RX_TO_IDLE_AUTO(rti),
        .I_SYNTH_CAL_STROBE(stb), .O_OSC_ENABLE(osc), .O_OSC_SETTLED(settled), .O_CHIP_READY_LOW(rdy_n),
        .O_SYNTH_CAL_START(cal));
    initial forever #2 clk = ~clk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        go <= 1'b1;
        ad <= a;
        dt <= d;
        @(posedge clk);
        go <= 1'b0;
    endtask : wrt
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        ad <= a;
        repeat (4) @(posedge clk);
        #1 chk(rdata, x);
    endtask : rd
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(8'h18, 8'h04);
        rd(8'h2A, 8'h00);
        e = $random(seed);
        wrt(8'h18, e[7:0]);
        wrt(8'h2A, 8'hFF);
        rd(8'h18, (e[0] ? e[7:0] & 8'hF3 | 8'h08 : e[7:0]) & 8'h3F);
        for (m = 0; m < 4; m++) begin
            stab <= 1'b0;
            wrt(8'h18, 8'(m * 4));
            @(posedge clk);
            stab <= 1'b1;
            n = 0;
            while (settled !== 1'b1 && n < 20000) begin
                @(posedge clk);
                #1 n++;
            end
            if (n == 20000) begin
                n_mismatch++;
                complete_run();
            end
            chk(n, (m ? 16 << 2 * m - 2 : 1) * 64 + 1);
            chk(rdy_n, 1'b0);
        end
        for (m = 0; m < 4; m++) begin
            wrt(8'h18, 8'(m * 16 + 4));
            for (k = 0; k < 8; k++) begin
                e = (m == 3 && k > 1) ? 1 : $unsigned($random(seed)) % 3;
                @(posedge clk);
                itr <= (e == 0);
                rti <= (e == 1);
                stb <= (e == 2);
                @(posedge clk);
                {itr, rti, stb} <= 3'h0;
                #1 acnt += (e == 1);
                chk(cal, e == 2 || e == 0 && m == 1 || e == 1 && (m == 2 || m == 3 && acnt % 4 == 0));
            end
        end
        wrt(8'h18, 8'h04);
        slp <= 1'b1;
        rd(8'h18, 8'h04);
        chk(osc, 1'b0);
        wrt(8'h18, 8'h05);
        rd(8'h18, 8'h09);
        chk(osc, 1'b1);
        complete_run();
    end
endmodule : wtac_ctrl_bench
